// ---- pidoc_pkg.sv ----
package pidoc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_GAINS = 8'h04;
   localparam logic [7:0] OFS_LIMITS = 8'h08;
   localparam logic [7:0] OFS_OFFSET = 8'h0c;
   localparam logic [7:0] OFS_FILTER = 8'h10;
   localparam logic [7:0] OFS_LOSS = 8'h14;
   localparam logic [7:0] OFS_SLEEP = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   // ----------------------------------------------------------------
   // Field positions and encodings
   // ----------------------------------------------------------------
   localparam int CTRL_POL_BIT = 3;
   localparam int CTRL_REVSEL_BIT = 4;
   localparam int CTRL_REVPRO_BIT = 5;
   localparam int CTRL_RUN_BIT = 6;
   localparam int CTRL_LOSS_LSB = 7;
   localparam logic [1:0] LOSS_ALARM = 2'h1;
   localparam logic [1:0] LOSS_FAULT = 2'h2;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_GAINS = 32'h0000_1010;
   localparam logic [31:0] RST_LIMITS = 32'h03e8_03e8;
   localparam logic [31:0] RST_OFFSET = 32'h0100_0000;
   localparam logic [31:0] RST_FILTER = 32'h0000_0000;
   localparam logic [31:0] RST_LOSS = 32'h03e8_0000;
   localparam logic [31:0] RST_SLEEP = 32'h03e8_0000;
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } pidoc_aph_t;
   typedef struct packed {
      logic pidDisable;
      logic intReset;
      logic intHold;
      logic softStartOff;
      logic resetCmd;
   } pidoc_mfi_t;
endpackage

// ---- pidoc_core.sv ----
`timescale 1ns/1ns
module pidoc_core #(
   parameter int TICK_CYCLES = pidoc_pkg::TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic signed [15:0] targetIn,
   input wire logic signed [15:0] feedbackIn,
   input wire logic signed [15:0] freqRefIn,
   input wire pidoc_pkg::pidoc_mfi_t mfiIn,
   output logic signed [15:0] freqOut,
   output logic reverseDir,
   output logic driveRun,
   output logic lossAlarm,
   output logic faultContact,
   output logic sleeping
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic signed [31:0] sat(input logic signed [31:0] x,
                                              input logic [15:0] lim);
      logic signed [31:0] l;
      l = $signed({16'h0000, lim});
      if (x > l)
      begin
         sat = l;
      end
      else if (x < -l)
      begin
         sat = -l;
      end
      else
      begin
         sat = x;
      end
   endfunction

   function automatic logic signed [31:0] sx(input logic signed [15:0] v);
      sx = {{16{v[15]}}, v};
   endfunction

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   pidoc_pkg::pidoc_aph_t aph_ff;
   logic [31:0] ctrl_ff, gains_ff, limits_ff, offset_ff, filter_ff, loss_ff, sleep_ff;
   logic [31:0] nxt_rdata;
   logic [31:0] status;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aph_ff <= '0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end
      else
      begin
         // Zero wait state: reads are answered from the address phase
         aph_ff.valid <= hsel && htrans[1] && hready;
         aph_ff.write <= hwrite;
         aph_ff.addr <= haddr[7:0];
         hrdata <= nxt_rdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_comb
   begin
      case (haddr[7:0])
         pidoc_pkg::OFS_CTRL: nxt_rdata = ctrl_ff;
         pidoc_pkg::OFS_GAINS: nxt_rdata = gains_ff;
         pidoc_pkg::OFS_LIMITS: nxt_rdata = limits_ff;
         pidoc_pkg::OFS_OFFSET: nxt_rdata = offset_ff;
         pidoc_pkg::OFS_FILTER: nxt_rdata = filter_ff;
         pidoc_pkg::OFS_LOSS: nxt_rdata = loss_ff;
         pidoc_pkg::OFS_SLEEP: nxt_rdata = sleep_ff;
         pidoc_pkg::OFS_STATUS: nxt_rdata = status;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_ff <= pidoc_pkg::RST_CTRL;
         gains_ff <= pidoc_pkg::RST_GAINS;
         limits_ff <= pidoc_pkg::RST_LIMITS;
         offset_ff <= pidoc_pkg::RST_OFFSET;
         filter_ff <= pidoc_pkg::RST_FILTER;
         loss_ff <= pidoc_pkg::RST_LOSS;
         sleep_ff <= pidoc_pkg::RST_SLEEP;
      end
      else if (aph_ff.valid && aph_ff.write)
      begin
         case (aph_ff.addr)
            pidoc_pkg::OFS_CTRL: ctrl_ff <= {23'h000000, hwdata[8:0]};
            pidoc_pkg::OFS_GAINS: gains_ff <= {8'h00, hwdata[23:0]};
            pidoc_pkg::OFS_LIMITS: limits_ff <= hwdata;
            pidoc_pkg::OFS_OFFSET: offset_ff <= hwdata;
            pidoc_pkg::OFS_FILTER: filter_ff <= {hwdata[31:16], 12'h000, hwdata[3:0]};
            pidoc_pkg::OFS_LOSS: loss_ff <= hwdata;
            pidoc_pkg::OFS_SLEEP: sleep_ff <= hwdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------
   logic [2:0] regulator_mode_select;
   logic output_polarity_select, reverse_output_select, reverse_prohibit, runCmd;
   logic [1:0] loss_detect_select;
   logic [7:0] kp, ki, derivative_time;
   logic [15:0] integral_limit, output_limit, output_gain, target_ramp_time;
   logic [15:0] loss_detect_time, sleep_delay;
   logic signed [15:0] offset_adjust, loss_detect_level, sleep_level;
   logic [3:0] output_filter_time;
   logic pidOn;

   assign regulator_mode_select = ctrl_ff[2:0];
   assign output_polarity_select = ctrl_ff[pidoc_pkg::CTRL_POL_BIT];
   assign reverse_output_select = ctrl_ff[pidoc_pkg::CTRL_REVSEL_BIT];
   assign reverse_prohibit = ctrl_ff[pidoc_pkg::CTRL_REVPRO_BIT];
   assign runCmd = ctrl_ff[pidoc_pkg::CTRL_RUN_BIT];
   assign loss_detect_select = ctrl_ff[pidoc_pkg::CTRL_LOSS_LSB +: 2];
   assign kp = gains_ff[7:0];
   assign ki = gains_ff[15:8];
   assign derivative_time = gains_ff[23:16];
   assign integral_limit = limits_ff[15:0];
   assign output_limit = limits_ff[31:16];
   assign offset_adjust = offset_ff[15:0];
   assign output_gain = offset_ff[31:16];
   assign output_filter_time = filter_ff[3:0];
   assign target_ramp_time = filter_ff[31:16];
   assign loss_detect_level = loss_ff[15:0];
   assign loss_detect_time = loss_ff[31:16];
   assign sleep_level = sleep_ff[15:0];
   assign sleep_delay = sleep_ff[31:16];
   // Modes above 4 are treated as disabled
   assign pidOn = (regulator_mode_select != 3'h0) && (regulator_mode_select < 3'h5)
                  && !mfiIn.pidDisable;
   assign status = {12'h000, sleeping, faultContact, lossAlarm, reverseDir, freqOut};

   // ----------------------------------------------------------------
   // Update tick
   // ----------------------------------------------------------------
   logic [31:0] tickCnt_ff;
   logic tick_ff;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tickCnt_ff <= 32'h0000_0000;
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= (tickCnt_ff == 32'(TICK_CYCLES - 1));
         tickCnt_ff <= (tickCnt_ff == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000
                       : tickCnt_ff + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // Target ramp
   // ----------------------------------------------------------------
   logic signed [15:0] rampT_ff;
   logic [15:0] rampCnt_ff;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rampT_ff <= 16'sh0000;
         rampCnt_ff <= 16'h0000;
      end
      else if (tick_ff)
      begin
         if ((mfiIn.softStartOff && driveRun) || target_ramp_time == 16'h0000)
         begin
            rampT_ff <= targetIn;
            rampCnt_ff <= 16'h0000;
         end
         else if (rampCnt_ff + 16'h0001 >= target_ramp_time)
         begin
            // One 0.1 percent step per ramp interval
            rampCnt_ff <= 16'h0000;
            if (rampT_ff < targetIn)
            begin
               rampT_ff <= rampT_ff + 16'sh0001;
            end
            else if (rampT_ff > targetIn)
            begin
               rampT_ff <= rampT_ff - 16'sh0001;
            end
         end
         else
         begin
            rampCnt_ff <= rampCnt_ff + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Regulator and output conditioning
   // ----------------------------------------------------------------
   logic signed [31:0] iAcc_ff, dPrev_ff, filt_ff;
   logic signed [31:0] err, dIn, pTerm, iNext, dTerm, pidLim, offs, filt, pol, gained, sum;
   logic signed [31:0] final32;
   logic negOut;
   logic iClear;

   assign iClear = mfiIn.intReset || mfiIn.resetCmd || !driveRun;

   always_comb
   begin
      err = sx(rampT_ff) - sx(feedbackIn);
      dIn = (regulator_mode_select[0]) ? err : -sx(feedbackIn);
      pTerm = ($signed({24'h000000, kp}) * err) >>> 4;
      iNext = sat(iAcc_ff + (($signed({24'h000000, ki}) * err) >>> 8), integral_limit);
      if (derivative_time == 8'h00)
      begin
         dTerm = 32'sh0000_0000;
      end
      else
      begin
         dTerm = $signed({24'h000000, derivative_time}) * (dIn - dPrev_ff);
      end
      pidLim = sat(pTerm + iAcc_ff + dTerm, output_limit);
      offs = pidLim + sx(offset_adjust);
      filt = filt_ff + ((offs - filt_ff) >>> output_filter_time);
      pol = output_polarity_select ? -filt : filt;
      gained = (pol * $signed({16'h0000, output_gain})) >>> 8;
      if (!pidOn)
      begin
         sum = sx(freqRefIn);
      end
      else if (regulator_mode_select >= 3'h3)
      begin
         sum = sx(freqRefIn) + gained;
      end
      else
      begin
         sum = gained;
      end
      sum = sat(sum, 16'h7fff);
      negOut = sum < 32'sh0000_0000;
      if (negOut && (reverse_prohibit || !reverse_output_select))
      begin
         final32 = 32'sh0000_0000;
      end
      else
      begin
         final32 = negOut ? -sum : sum;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         iAcc_ff <= 32'sh0000_0000;
         dPrev_ff <= 32'sh0000_0000;
         filt_ff <= 32'sh0000_0000;
         freqOut <= 16'sh0000;
         reverseDir <= 1'b0;
      end
      else if (tick_ff)
      begin
         if (iClear || !pidOn)
         begin
            iAcc_ff <= 32'sh0000_0000;
         end
         else if (!mfiIn.intHold)
         begin
            iAcc_ff <= iNext;
         end
         dPrev_ff <= dIn;
         filt_ff <= filt;
         freqOut <= final32[15:0];
         reverseDir <= negOut && !reverse_prohibit && reverse_output_select;
      end
   end

   // ----------------------------------------------------------------
   // Feedback loss and sleep
   // ----------------------------------------------------------------
   logic [15:0] lossCnt_ff, sleepCnt_ff;
   logic lossHit;
   logic sleepCond;

   assign lossHit = (lossCnt_ff >= loss_detect_time);
   // Sleeping waits for target above level, awake waits for below
   assign sleepCond = sleeping ? (targetIn > sleep_level) : (targetIn < sleep_level);

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lossCnt_ff <= 16'h0000;
         lossAlarm <= 1'b0;
      end
      else if (tick_ff)
      begin
         if (!pidOn || loss_detect_select == 2'h0 || feedbackIn >= loss_detect_level)
         begin
            lossCnt_ff <= 16'h0000;
            lossAlarm <= 1'b0;
         end
         else if (lossHit)
         begin
            lossAlarm <= (loss_detect_select == pidoc_pkg::LOSS_ALARM);
         end
         else
         begin
            lossCnt_ff <= lossCnt_ff + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         faultContact <= 1'b0;
      end
      else if (tick_ff && pidOn && loss_detect_select == pidoc_pkg::LOSS_FAULT
               && feedbackIn < loss_detect_level && lossHit)
      begin
         // Detection wins over a simultaneous reset command
         faultContact <= 1'b1;
      end
      else if (mfiIn.resetCmd)
      begin
         faultContact <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sleepCnt_ff <= 16'h0000;
         sleeping <= 1'b0;
      end
      else if (!pidOn)
      begin
         sleepCnt_ff <= 16'h0000;
         sleeping <= 1'b0;
      end
      else if (tick_ff)
      begin
         if (!sleepCond)
         begin
            sleepCnt_ff <= 16'h0000;
         end
         else if (sleepCnt_ff + 16'h0001 >= sleep_delay)
         begin
            sleepCnt_ff <= 16'h0000;
            sleeping <= !sleeping;
         end
         else
         begin
            sleepCnt_ff <= sleepCnt_ff + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         driveRun <= 1'b0;
      end
      else
      begin
         driveRun <= runCmd && !faultContact && !sleeping;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence seqTick;
      tick_ff;
   endsequence
   sequence seqHoldTick;
      tick_ff && mfiIn.intHold && !iClear && pidOn;
   endsequence

   AST_INT_LIMIT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      seqTick |=> (iAcc_ff <= $signed({16'h0000, integral_limit})
                   && iAcc_ff >= -$signed({16'h0000, integral_limit})))
      else $error("integral term beyond limit");
   AST_OUT_LIMIT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pidLim <= $signed({16'h0000, output_limit}) && pidLim >= -$signed({16'h0000, output_limit}))
      else $error("regulator result beyond output limit");
   AST_NO_REV_PROHIBIT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (seqTick and reverse_prohibit) |=> !reverseDir && !freqOut[15])
      else $error("reverse while prohibited");
   AST_NO_REV_SEL: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (seqTick and !reverse_output_select) |=> !reverseDir)
      else $error("reverse without reverse select");
   AST_FAULT_STOP: assert property (@(posedge clk_sys) disable iff (!arst_n)
      faultContact |=> !driveRun)
      else $error("drive running with fault");
   AST_SLEEP_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !pidOn |=> !sleeping ##1 driveRun == $past(runCmd && !faultContact))
      else $error("sleep active with regulator disabled");
   AST_DERIV_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (derivative_time == 8'h00) |-> (dTerm == 32'sh0000_0000))
      else $error("derivative active at zero time");
   AST_LOSS_RESTART: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (seqTick and feedbackIn >= loss_detect_level) |=> lossCnt_ff == 16'h0000 && !lossAlarm)
      else $error("loss timer not restarted");
   AST_INT_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      seqHoldTick |=> $stable(iAcc_ff))
      else $error("integral moved while held");
   AST_SOFT_BYPASS: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (seqTick and mfiIn.softStartOff && driveRun) |=> rampT_ff == $past(targetIn))
      else $error("ramp not bypassed");
endmodule

// ---- pidoc_sensor.sv ----
`timescale 1ns/1ns
module pidoc_sensor (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic signed [15:0] fbSet,
   input wire logic signed [15:0] refSet,
   input wire logic lost,
   output logic signed [15:0] feedbackIn,
   output logic signed [15:0] freqRefIn
);
   // ----------------------------------------------------------------
   // Sensor and reference path
   // ----------------------------------------------------------------
   // A broken sensor wire reads as zero, never as the last value
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         feedbackIn <= 16'sh0000;
         freqRefIn <= 16'sh0000;
      end
      else
      begin
         feedbackIn <= lost ? 16'sh0000 : fbSet;
         freqRefIn <= refSet;
      end
   end
endmodule

// ---- pid_output_conditioning_bench.sv ----
`timescale 1ns/1ns
module pid_output_conditioning_bench;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rdv;
   logic hreadyout, hresp, lost = 1'b0;
   logic signed [15:0] targetIn = 16'sh0000;
   logic signed [15:0] fbSet = 16'sh0000;
   logic signed [15:0] refSet = 16'sh0000;
   logic signed [15:0] feedbackIn, freqRefIn, freqOut, fo;
   pidoc_pkg::pidoc_mfi_t mfiIn = '0;
   logic reverseDir, driveRun, lossAlarm, faultContact, sleeping;
   logic rv, dr, la, fc, sl;
   int failures = 0;
   int check_count = 0;

   always #2 clk_sys = ~clk_sys;

   // Short tick so that millisecond timers fit the run
   pidoc_core #(.TICK_CYCLES(8)) pidoc_core_i (
      .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .targetIn(targetIn),
      .feedbackIn(feedbackIn), .freqRefIn(freqRefIn), .mfiIn(mfiIn), .freqOut(freqOut),
      .reverseDir(reverseDir), .driveRun(driveRun), .lossAlarm(lossAlarm),
      .faultContact(faultContact), .sleeping(sleeping));

   pidoc_sensor pidoc_sensor_i (
      .clk_sys(clk_sys), .arst_n(arst_n), .fbSet(fbSet), .refSet(refSet), .lost(lost),
      .feedbackIn(feedbackIn), .freqRefIn(freqRefIn));

   // ----------------------------------------------------------------
   // Common tasks
   // ----------------------------------------------------------------
   task end_sim;
      begin
         if (failures == 0 && check_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         check_count++;
         if (got !== exp)
         begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // Mid-cycle sampling gives the value that the next rising edge sees
   task hw;
      int n;
      logic rdy;
      begin
         n = 0;
         rdy = 1'b0;
         while (rdy !== 1'b1 && n <= 50)
         begin
            @(negedge clk_sys);
            rdy = hreadyout;
            rdv = hrdata;
            n++;
            @(posedge clk_sys);
         end
         if (rdy !== 1'b1)
         begin
            failures++;
            end_sim;
         end
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      begin
         hsel <= 1'b1;
         haddr <= {24'h0, a};
         htrans <= 2'h2;
         hwrite <= w;
         hw;
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         hw;
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      begin
         bus(1'b0, a, 32'h0);
         chk(rdv, e);
         chk(32'(hresp), 32'h0);
      end
   endtask

   task tk(input int n);
      begin
         repeat (n * 8) @(posedge clk_sys);
         @(negedge clk_sys);
         {fo, rv, dr, la, fc, sl} = {freqOut, reverseDir, driveRun, lossAlarm, faultContact,
            sleeping};
         @(posedge clk_sys);
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_regs;
      logic [31:0] rv0 [7];
      begin
         rv0 = '{pidoc_pkg::RST_CTRL, pidoc_pkg::RST_GAINS, pidoc_pkg::RST_LIMITS,
            pidoc_pkg::RST_OFFSET, pidoc_pkg::RST_FILTER, pidoc_pkg::RST_LOSS,
            pidoc_pkg::RST_SLEEP};
         for (int i = 0; i < 7; i++)
            rd(8'(i * 4), rv0[i]);
         rd(8'h20, 32'h0);
         wr(pidoc_pkg::OFS_STATUS, 32'hffff_ffff);
         rd(pidoc_pkg::OFS_STATUS, 32'h0);
         wr(pidoc_pkg::OFS_CTRL, 32'hffff_ffff);
         rd(pidoc_pkg::OFS_CTRL, 32'h0000_01ff);
      end
   endtask

   task t_bypass;
      begin
         refSet <= -16'sd200;
         wr(pidoc_pkg::OFS_CTRL, 32'h40);
         tk(3);
         chk({rv, fo}, 17'h0);
         wr(pidoc_pkg::OFS_CTRL, 32'h50);
         tk(3);
         chk({rv, fo}, {1'b1, 16'd200});
         wr(pidoc_pkg::OFS_CTRL, 32'h70);
         tk(3);
         chk({rv, fo}, 17'h0);
         refSet <= 16'sd150;
         mfiIn.pidDisable <= 1'b1;
         wr(pidoc_pkg::OFS_CTRL, 32'h51);
         tk(3);
         chk({rv, fo}, 17'd150);
         mfiIn.pidDisable <= 1'b0;
         refSet <= 16'sd0;
      end
   endtask

   task t_chain;
      begin
         targetIn <= 16'sd500;
         wr(pidoc_pkg::OFS_GAINS, 32'h10);
         wr(pidoc_pkg::OFS_LIMITS, 32'h012c_03e8);
         wr(pidoc_pkg::OFS_OFFSET, 32'h0200_0032);
         wr(pidoc_pkg::OFS_CTRL, 32'h42);
         tk(4);
         chk({rv, fo}, 17'd700);
         wr(pidoc_pkg::OFS_CTRL, 32'h59);
         tk(4);
         chk({rv, fo}, {1'b1, 16'd700});
         rd(pidoc_pkg::OFS_STATUS, 32'h0001_02bc);
         wr(pidoc_pkg::OFS_CTRL, 32'h49);
         tk(4);
         chk({rv, fo}, 17'h0);
         wr(pidoc_pkg::OFS_OFFSET, 32'h0100_0000);
         refSet <= 16'sd100;
         wr(pidoc_pkg::OFS_CTRL, 32'h43);
         tk(4);
         chk({rv, fo}, 17'd400);
         wr(pidoc_pkg::OFS_CTRL, 32'h44);
         tk(3);
         chk({rv, fo}, 17'd400);
         refSet <= 16'sd0;
      end
   endtask

   task t_int;
      begin
         wr(pidoc_pkg::OFS_GAINS, 32'hff00);
         wr(pidoc_pkg::OFS_LIMITS, 32'h03e8_0096);
         wr(pidoc_pkg::OFS_CTRL, 32'h41);
         tk(4);
         chk({rv, fo}, 17'd150);
         mfiIn.intHold <= 1'b1;
         targetIn <= -16'sd500;
         tk(4);
         chk({rv, fo}, 17'd150);
         mfiIn.intHold <= 1'b0;
         mfiIn.intReset <= 1'b1;
         wr(pidoc_pkg::OFS_CTRL, 32'h51);
         tk(3);
         chk({rv, fo}, 17'h0);
         mfiIn.intReset <= 1'b0;
         targetIn <= 16'sd500;
         wr(pidoc_pkg::OFS_GAINS, 32'h10);
         wr(pidoc_pkg::OFS_LIMITS, pidoc_pkg::RST_LIMITS);
      end
   endtask

   task t_loss;
      begin
         fbSet <= 16'sd200;
         wr(pidoc_pkg::OFS_LOSS, 32'h0006_0064);
         wr(pidoc_pkg::OFS_CTRL, 32'hc1);
         tk(2);
         lost <= 1'b1;
         tk(3);
         chk(la, 1'b0);
         tk(6);
         chk({la, dr}, 2'b11);
         lost <= 1'b0;
         tk(3);
         chk(la, 1'b0);
         lost <= 1'b1;
         tk(4);
         lost <= 1'b0;
         tk(1);
         lost <= 1'b1;
         tk(4);
         chk(la, 1'b0);
         wr(pidoc_pkg::OFS_CTRL, 32'h141);
         tk(8);
         chk({fc, dr}, 2'b10);
         lost <= 1'b0;
         mfiIn.resetCmd <= 1'b1;
         tk(2);
         mfiIn.resetCmd <= 1'b0;
         tk(2);
         chk({fc, dr}, 2'b01);
         wr(pidoc_pkg::OFS_CTRL, 32'h41);
      end
   endtask

   task t_sleep;
      begin
         wr(pidoc_pkg::OFS_SLEEP, 32'h0004_0064);
         targetIn <= 16'sd50;
         tk(2);
         chk({sl, dr}, 2'b01);
         tk(6);
         chk({sl, dr}, 2'b10);
         targetIn <= 16'sd300;
         tk(8);
         chk({sl, dr}, 2'b01);
         wr(pidoc_pkg::OFS_CTRL, 32'h40);
         targetIn <= 16'sd50;
         tk(8);
         chk({sl, dr}, 2'b01);
         wr(pidoc_pkg::OFS_SLEEP, pidoc_pkg::RST_SLEEP);
         wr(pidoc_pkg::OFS_CTRL, 32'h41);
      end
   endtask

   task t_ramp;
      begin
         // Feedback left at 200 by the loss test would pin the output at zero
         fbSet <= 16'sd0;
         targetIn <= 16'sd0;
         tk(3);
         wr(pidoc_pkg::OFS_FILTER, 32'h0002_0000);
         targetIn <= 16'sd400;
         tk(10);
         chk(32'(fo > 16'sd0 && fo < 16'sd20), 32'h1);
         mfiIn.softStartOff <= 1'b1;
         tk(3);
         chk({rv, fo}, 17'd400);
         mfiIn.softStartOff <= 1'b0;
         wr(pidoc_pkg::OFS_FILTER, 32'h2);
         targetIn <= 16'sd0;
         tk(2);
         chk(32'(fo > 16'sd0 && fo < 16'sd400), 32'h1);
      end
   endtask

   initial
   begin
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      t_regs;
      t_bypass;
      t_chain;
      t_int;
      t_loss;
      t_sleep;
      t_ramp;
      end_sim;
   end

   initial
   begin
      repeat (100000) @(posedge clk_sys);
      failures++;
      end_sim;
   end
endmodule
